//--- rtl/trm_pkg.sv
// How it works
// - core reset clears core logic only; test reset clears emulation logic and, through the valid crossing, the core-side mode outputs.
// - core starts running once core reset is released, whatever test reset does.
// - while test reset is low, test port and emulation logic stay in reset.
// - test reset pin is weakly pulled low, so an open pin means reset.
// - after core reset release, test reset rising edge captures the mode pins.
// - captured mode selects boundary scan or emulation.
package trm_pkg;

  // width of the scan-mode selection
  localparam int MODE_W = 2;

  typedef logic [MODE_W-1:0] trm_mode_t;

  // captured mode while the test logic sits in reset
  localparam trm_mode_t MODE_RST = 2'h0;

  // selection code that picks boundary scan; every other code picks emulation
  localparam trm_mode_t SEL_BOUNDARY_SCAN = 2'h0;

  // reset value of the pulldown enable
  localparam logic PD_EN_RST = 1'h1;

endpackage

//--- rtl/trm_mode_if.sv
`timescale 1ns/1ns
// carries the test-domain mode latch state to and from the core side
interface trm_mode_if;
  import trm_pkg::*;

  logic      trst_lvl;   // resolved test reset pin level, low = reset
  logic      core_ready; // core reset released, core clock domain level
  trm_mode_t sel;        // raw selection pins
  trm_mode_t sel_sync;   // selection pins after two test-clock flops
  logic      core_seen;  // core_ready after two test-clock flops
  logic      test_rst_n; // test reset after two test-clock flops
  trm_mode_t mode;       // captured mode
  logic      mode_valid; // captured mode is valid

  modport latch (
    input  trst_lvl,
    input  core_ready,
    input  sel,
    output sel_sync,
    output core_seen,
    output test_rst_n,
    output mode,
    output mode_valid
  );

  modport core (
    output trst_lvl,
    output core_ready,
    output sel,
    input  sel_sync,
    input  core_seen,
    input  test_rst_n,
    input  mode,
    input  mode_valid
  );

endinterface

//--- rtl/trm_mode_latch.sv
`timescale 1ns/1ns
module trm_mode_latch (
  // test clock
  input wire logic  test_clock_i,
  // mode latch signals
  trm_mode_if.latch mif
);
  import trm_pkg::*;

  logic      trst_m_r;
  logic      trst_s_r;
  logic      trst_d_r;
  logic      core_m_r;
  logic      core_s_r;
  trm_mode_t sel_m_r;
  trm_mode_t sel_s_r;
  trm_mode_t mode_r;
  logic      valid_r;
  logic      trst_rise;
  logic      capture;

  // two-flop synchronisers on the test clock
  always_ff @(posedge test_clock_i) begin
    trst_m_r <= mif.trst_lvl;
    trst_s_r <= trst_m_r;
    core_m_r <= mif.core_ready;
    core_s_r <= core_m_r;
    sel_m_r  <= mif.sel;
    sel_s_r  <= sel_m_r;
  end

  // rising test reset, only counted once the core is out of reset
  assign trst_rise = trst_s_r & ~trst_d_r;
  assign capture   = trst_rise & core_s_r;

  // mode latch, reset synchronously by the test reset alone
  // test reset only
  always_ff @(posedge test_clock_i) begin
    trst_d_r <= trst_s_r;
    if (!trst_s_r) begin
      mode_r  <= MODE_RST;
      valid_r <= 1'h0;
    end else if (capture) begin
      mode_r  <= sel_s_r;
      valid_r <= 1'h1;
    end
  end

  // held until next assertion (no other load path above)
  assign mif.mode       = mode_r;
  assign mif.mode_valid = valid_r;
  assign mif.test_rst_n = trst_s_r;
  assign mif.core_seen  = core_s_r;
  assign mif.sel_sync   = sel_s_r;

endmodule

//--- rtl/trm_top.sv
`timescale 1ns/1ns
module trm_top (
  // core clock and core reset
  input  wire logic               REF_CLK_I,
  input  wire logic               NRST_I,
  // test port pins
  input  wire logic               TEST_CLK_I,
  input  wire logic               TEST_RST_N_I,
  input  wire logic               TEST_RST_DRIVEN_I,
  input  wire logic [trm_pkg::MODE_W-1:0] SCAN_MODE_SEL_I,
  // core status
  output logic                    CORE_RUN_O,
  output logic                    TEST_RST_PD_EN_O,
  // test domain status
  output logic                    TEST_LOGIC_RST_N_O,
  // captured mode, core domain
  output trm_pkg::trm_mode_t      SCAN_MODE_O,
  output logic                    SCAN_MODE_VALID_O,
  output logic                    BOUNDARY_SCAN_EN_O,
  output logic                    EMULATION_EN_O
);
  import trm_pkg::*;

  trm_mode_if mif ();

  logic      core_run_r;
  logic      pd_en_r;
  logic      vld_m_r;
  logic      vld_s_r;
  logic      vld_d_r;
  logic      vld_rise;
  trm_mode_t mode_out_r;
  trm_mode_t mode_out_nxt;
  logic      valid_out_r;
  logic      boundary_scan_logic_r;
  logic      boundary_scan_logic_nxt;
  logic      emu_r;
  logic      emu_nxt;

  assign mif.trst_lvl   = TEST_RST_DRIVEN_I ? TEST_RST_N_I : 1'h0;
  assign mif.sel        = SCAN_MODE_SEL_I;
  assign mif.core_ready = core_run_r;

  // test-clock side latch
  trm_mode_latch u_latch (
    .test_clock_i (TEST_CLK_I),
    .mif    (mif.latch)
  );

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      core_run_r <= 1'h0;
    end else begin
      core_run_r <= 1'h1;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pd_en_r <= PD_EN_RST;
    end else begin
      pd_en_r <= PD_EN_RST;
    end
  end

  // valid level crosses into the core clock; mode word is stable while valid
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      vld_m_r <= 1'h0;
      vld_s_r <= 1'h0;
      vld_d_r <= 1'h0;
    end else begin
      vld_m_r <= mif.mode_valid;
      vld_s_r <= vld_m_r;
      vld_d_r <= vld_s_r;
    end
  end

  assign vld_rise     = vld_s_r & ~vld_d_r;
  assign mode_out_nxt = !vld_s_r ? MODE_RST : (vld_rise ? mif.mode : mode_out_r);
  assign boundary_scan_logic_nxt    = vld_s_r && (mode_out_nxt == SEL_BOUNDARY_SCAN);
  assign emu_nxt      = vld_s_r && (mode_out_nxt != SEL_BOUNDARY_SCAN);

  // mode outputs, cleared by the core reset
  // core reset only
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      mode_out_r  <= MODE_RST;
      valid_out_r <= 1'h0;
      boundary_scan_logic_r     <= 1'h0;
      emu_r       <= 1'h0;
    end else begin
      mode_out_r  <= mode_out_nxt;
      valid_out_r <= vld_s_r;
      boundary_scan_logic_r     <= boundary_scan_logic_nxt;
      emu_r       <= emu_nxt;
    end
  end

  // output drive
  assign CORE_RUN_O         = core_run_r;
  assign TEST_RST_PD_EN_O   = pd_en_r;
  assign TEST_LOGIC_RST_N_O = mif.test_rst_n;
  assign SCAN_MODE_O        = mode_out_r;
  assign SCAN_MODE_VALID_O  = valid_out_r;
  assign BOUNDARY_SCAN_EN_O = boundary_scan_logic_r;
  assign EMULATION_EN_O     = emu_r;

  // core domain checks

  core_boot_a : assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    $past(NRST_I) |-> CORE_RUN_O
  ) else $error("core not running after core reset release");

  pd_enable_a : assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    TEST_RST_PD_EN_O
  ) else $error("test reset pulldown not enabled");

  mode_decode_a : assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    SCAN_MODE_VALID_O |->
      (BOUNDARY_SCAN_EN_O == (SCAN_MODE_O == SEL_BOUNDARY_SCAN)) &&
      (EMULATION_EN_O == !BOUNDARY_SCAN_EN_O)
  ) else $error("mode enables do not match captured mode");

  mode_idle_a : assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    !SCAN_MODE_VALID_O |-> !BOUNDARY_SCAN_EN_O && !EMULATION_EN_O
      && (SCAN_MODE_O == MODE_RST)
  ) else $error("mode enable active without captured mode");

  mode_cross_a : assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    $rose(vld_s_r) |=> SCAN_MODE_VALID_O && (SCAN_MODE_O == $past(mif.mode))
  ) else $error("captured mode not carried into core domain");

  core_rst_clear_a : assert property (
    @(posedge REF_CLK_I)
    !NRST_I |=>
      !CORE_RUN_O && !SCAN_MODE_VALID_O
      && !BOUNDARY_SCAN_EN_O && !EMULATION_EN_O
  ) else $error("core reset did not clear core side state");

  mode_keep_a : assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    SCAN_MODE_VALID_O && $past(SCAN_MODE_VALID_O)
      |-> $stable(SCAN_MODE_O)
  ) else $error("core side mode changed while valid");

  // test domain checks

  pulldown_rst_a : assert property (
    @(posedge TEST_CLK_I) disable iff (TEST_RST_DRIVEN_I)
    !TEST_RST_DRIVEN_I ##1 !TEST_RST_DRIVEN_I |=> !mif.test_rst_n
  ) else $error("undriven test reset pin did not reset test logic");

  reset_holds_a : assert property (
    @(posedge TEST_CLK_I) disable iff (1'b0)
    !mif.test_rst_n |=> !mif.mode_valid && (mif.mode == MODE_RST)
  ) else $error("test logic left reset state while test reset low");

  capture_edge_a : assert property (
    @(posedge TEST_CLK_I) disable iff (!TEST_RST_DRIVEN_I)
    $rose(mif.test_rst_n) && mif.core_seen |=>
      mif.mode_valid && (mif.mode == $past(mif.sel_sync))
  ) else $error("mode not captured on test reset rising edge");

  no_capture_a : assert property (
    @(posedge TEST_CLK_I) disable iff (!TEST_RST_DRIVEN_I)
    $rose(mif.test_rst_n) && !mif.core_seen |=> !mif.mode_valid
  ) else $error("mode captured while core still in reset");

  mode_hold_a : assert property (
    @(posedge TEST_CLK_I) disable iff (!TEST_RST_DRIVEN_I)
    mif.mode_valid && mif.test_rst_n |=> mif.mode_valid && $stable(mif.mode)
  ) else $error("captured mode changed before test reset asserted");

  separate_reset_a : assert property (
    @(posedge TEST_CLK_I) disable iff (!TEST_RST_DRIVEN_I)
    mif.mode_valid && mif.test_rst_n && !NRST_I |=> mif.mode_valid
  ) else $error("core reset disturbed emulation logic");

  test_rst_sync_a : assert property (
    @(posedge TEST_CLK_I) disable iff (!TEST_RST_DRIVEN_I)
    TEST_LOGIC_RST_N_O ==
      $past(mif.trst_lvl, 2)
  ) else $error("test logic reset status does not follow test reset pin");

  // main scenarios

  emu_cap_c : cover property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    $rose(EMULATION_EN_O)
  );

  boundary_scan_logic_cap_c : cover property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    $rose(BOUNDARY_SCAN_EN_O)
  );

  boot_in_trst_c : cover property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    CORE_RUN_O && !SCAN_MODE_VALID_O
  );

  late_core_c : cover property (
    @(posedge TEST_CLK_I) disable iff (!TEST_RST_DRIVEN_I)
    $rose(mif.test_rst_n) && !mif.core_seen
  );

  sel_move_c : cover property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    SCAN_MODE_VALID_O && $changed(SCAN_MODE_SEL_I)
  );

endmodule

//--- sim/trm_jtag_ctrl.sv
`timescale 1ns/1ns
// far-side controller: test clock and test reset pin
module trm_jtag_ctrl (
  output logic test_clock_o,
  output logic trst_n_o,
  output logic driven_o
);
  logic pin_r;

  initial begin
    test_clock_o   = 1'b0;
    driven_o = 1'b0;
    pin_r    = 1'b1;
    forever #6 test_clock_o = ~test_clock_o;
  end

  // a floating pin reads high here, so only the device pull resets
  assign trst_n_o = driven_o ? pin_r : 1'b1;

  // change the pin after a test clock edge, then hold it
  task automatic set_pin(input logic drv, input logic lvl);
    @(posedge test_clock_o);
    #1;
    driven_o = drv;
    pin_r    = lvl;
    repeat (6) @(posedge test_clock_o);
    #1;
  endtask
endmodule

//--- sim/trm_top_test.sv
`timescale 1ns/1ns
module trm_top_test;
  import trm_pkg::*;
  logic       ref_clk, nrst, test_clock, trst_n, drv;
  logic [1:0] sel, m, mode;
  logic       run, pd, tlr, vld, bs, emu;
  int         miscompares = 0;
  int         n_compared = 0;
  logic [7:0] lfsr = 8'h41;

  trm_jtag_ctrl ctl_u (.test_clock_o(test_clock), .trst_n_o(trst_n), .driven_o(drv));
  trm_top dut_u (.REF_CLK_I(ref_clk), .NRST_I(nrst), .TEST_CLK_I(test_clock),
    .TEST_RST_N_I(trst_n), .TEST_RST_DRIVEN_I(drv), .SCAN_MODE_SEL_I(sel),
    .CORE_RUN_O(run), .TEST_RST_PD_EN_O(pd), .TEST_LOGIC_RST_N_O(tlr),
    .SCAN_MODE_O(mode), .SCAN_MODE_VALID_O(vld), .BOUNDARY_SCAN_EN_O(bs),
    .EMULATION_EN_O(emu));

  // core clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  function automatic logic [7:0] lfsr_next(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  function automatic logic exp_bs(input logic [1:0] c);
    return c == SEL_BOUNDARY_SCAN;
  endfunction

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [1:0] e, input logic [1:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic wait_vld(input logic v);
    int i;
    for (i = 0; i < 200 && vld !== v; i++) begin
      @(posedge ref_clk);
      #1;
    end
    if (i == 200) begin
      chk("valid_wait", v, vld);
      results();
    end
  endtask

  // one low-high cycle of test reset capturing code c
  task automatic cap(input logic [1:0] c);
    @(posedge ref_clk);
    #1;
    sel = c;
    ctl_u.set_pin(1'b1, 1'b0);
    wait_vld(1'b0);
    ctl_u.set_pin(1'b1, 1'b1);
    wait_vld(1'b1);
    chk("mode", c, mode);
    chk("boundary_scan_logic_en", exp_bs(c), bs);
    chk("emu_en", !exp_bs(c), emu);
    chk("tlr", 1, tlr);
    sel = ~c;
    repeat (20) @(posedge ref_clk);
    #1;
    chk("mode_hold", c, mode);
  endtask

  initial begin
    nrst = 1'b0;
    sel  = 2'h0;
    repeat (4) @(posedge ref_clk);
    #1;
    chk("core_run", 0, run);
    chk("pd_en", PD_EN_RST, pd);
    chk("tlr", 0, tlr);
    nrst = 1'b1;
    @(posedge ref_clk);
    #1;
    chk("core_run", 1, run);
    chk("pd_en", 2'h1, pd);
    ctl_u.set_pin(1'b0, 1'b1);
    repeat (30) @(posedge ref_clk);
    #1;
    chk("tlr", 0, tlr);
    chk("valid", 0, vld);
    for (int k = 0; k < 10; k++) begin
      m = (k < 4) ? 2'(k) : lfsr[1:0];
      lfsr = lfsr_next(lfsr);
      cap(m);
    end
    // core reset alone keeps the captured mode
    nrst = 1'b0;
    #2;
    chk("valid", 0, vld);
    chk("core_run", 0, run);
    @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    wait_vld(1'b1);
    chk("mode_keep", m, mode);
    // test reset rising while core in reset captures nothing
    nrst = 1'b0;
    ctl_u.set_pin(1'b1, 1'b0);
    ctl_u.set_pin(1'b1, 1'b1);
    @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    repeat (40) @(posedge ref_clk);
    #1;
    chk("valid_refused", 0, vld);
    chk("core_run", 1, run);
    results();
  end
endmodule
